//--- frcu_top.v
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "frcu_regs.vh"
module frcu_top (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // interrupt request
    input  wire        maskable_interrupt_pin,
    output reg         int_service_req,
    // flag state
    output reg  [63:0] wide_flags_register
);
    wire        rd_take;
    wire [5:0]  rd_off;
    wire        wr_en;
    wire [5:0]  wr_off;

    reg  [7:0]  flags_image_byte_reg;
    reg  [63:0] stack_in;
    reg  [63:0] stack_out;
    reg  [4:0]  mode_reg;
    reg  [31:0] source_index_reg;
    reg  [31:0] dest_index_reg;
    reg         op_fault;
    reg  [3:0]  last_op;

    reg  [63:0] next_flags;
    reg  [7:0]  next_byte;
    reg  [63:0] next_stack_out;
    reg  [31:0] next_src;
    reg  [31:0] next_dst;
    reg         next_fault_set;
    reg  [31:0] pop_mask;
    reg  [31:0] pop_src;
    reg  [31:0] step;
    reg  [63:0] push_img;

    wire        op_go;
    wire [3:0]  op_code;
    wire [1:0]  op_size;
    wire        long_mode;
    wire        prot_mode;
    wire        feat_report_bit;
    wire [1:0]  current_privilege_level;
    wire [1:0]  io_privilege_level;
    wire        io_ok;
    wire        if_ok;
    wire        int_op_ok;
    wire        byte_op_ok;
    wire        fault_clr;

    frcu_ahb u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .rd_take   (rd_take),
        .rd_off    (rd_off),
        .wr_en     (wr_en),
        .wr_off    (wr_off),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    assign op_go = wr_en & (wr_off == `FRCU_OFF_OP);
    assign op_code = hwdata[3:0];
    assign op_size = hwdata[5:4];
    assign fault_clr = wr_en & (wr_off == `FRCU_OFF_STAT) &
                       hwdata[`FRCU_ST_FAULT];

    assign long_mode = mode_reg[`FRCU_MD_LONG];
    assign prot_mode = mode_reg[`FRCU_MD_PROT];
    assign feat_report_bit = mode_reg[`FRCU_MD_FEAT];
    assign current_privilege_level =
        mode_reg[`FRCU_MD_PRIV_HI:`FRCU_MD_PRIV_LO];
    assign io_privilege_level =
        wide_flags_register[`FRCU_B_IOLVL_HI:`FRCU_B_IOLVL_LO];

    // privilege gating shared by both pop widths
    assign io_ok = (current_privilege_level == 2'h0);
    assign if_ok = (io_privilege_level >= current_privilege_level);
    // real mode has no privilege check on interrupt enable ops
    assign int_op_ok = ~prot_mode | if_ok;
    assign byte_op_ok = ~long_mode | feat_report_bit;

    // pop merge mask and source word
    always @* begin
        pop_mask = `FRCU_M_POPW;
        if (op_code == `FRCU_OP_POPD) begin
            pop_mask = pop_mask | `FRCU_M_POPD;
        end
        if (io_ok) begin
            pop_mask = pop_mask | `FRCU_M_IOLVL;
        end
        // gated bits simply stay; no fault raised
        if (if_ok) begin
            pop_mask = pop_mask | `FRCU_M_IF;
        end
        if (op_code == `FRCU_OP_POPD) begin
            pop_src = stack_in[31:0];
        end else begin
            pop_src = {16'h0000, stack_in[15:0]};
        end
    end

    // pushed image with resume and virtual-mode positions cleared
    always @* begin
        push_img = wide_flags_register & ~`FRCU_M_PUSH_CLR;
        if (!long_mode) begin
            push_img = {32'h00000000, push_img[31:0]};
        end
    end

    // element size in bytes: 1, 2, 4 or 8
    always @* begin
        step = 32'h00000001 << op_size;
    end

    // operation datapath
    always @* begin
        next_flags = wide_flags_register;
        next_byte = flags_image_byte_reg;
        next_stack_out = stack_out;
        next_src = source_index_reg;
        next_dst = dest_index_reg;
        next_fault_set = 1'b0;
        case (op_code)
            `FRCU_OP_CSET: begin
                next_flags[`FRCU_B_CARRY] = 1'b1;
            end
            `FRCU_OP_CCLR: begin
                next_flags[`FRCU_B_CARRY] = 1'b0;
            end
            `FRCU_OP_CINV: begin
                next_flags[`FRCU_B_CARRY] = ~wide_flags_register[`FRCU_B_CARRY];
            end
            `FRCU_OP_DSET: begin
                next_flags[`FRCU_B_DIR] = 1'b1;
            end
            `FRCU_OP_DCLR: begin
                next_flags[`FRCU_B_DIR] = 1'b0;
            end
            `FRCU_OP_ISET: begin
                if (int_op_ok) begin
                    next_flags[`FRCU_B_IF] = 1'b1;
                end else begin
                    next_fault_set = 1'b1;
                end
            end
            `FRCU_OP_ICLR: begin
                if (int_op_ok) begin
                    next_flags[`FRCU_B_IF] = 1'b0;
                end else begin
                    next_fault_set = 1'b1;
                end
            end
            `FRCU_OP_LOADB: begin
                if (byte_op_ok) begin
                    // bits 5, 3, 1 keep their old content; flags untouched
                    next_byte[7] = wide_flags_register[`FRCU_B_SIGN];
                    next_byte[6] = wide_flags_register[`FRCU_B_ZERO];
                    next_byte[4] = wide_flags_register[`FRCU_B_AUX];
                    next_byte[2] = wide_flags_register[`FRCU_B_PARITY];
                    next_byte[0] = wide_flags_register[`FRCU_B_CARRY];
                end else begin
                    next_fault_set = 1'b1;
                end
            end
            `FRCU_OP_STOREB: begin
                if (byte_op_ok) begin
                    next_flags[`FRCU_B_SIGN] = flags_image_byte_reg[7];
                    next_flags[`FRCU_B_ZERO] = flags_image_byte_reg[6];
                    next_flags[`FRCU_B_AUX] = flags_image_byte_reg[4];
                    next_flags[`FRCU_B_PARITY] = flags_image_byte_reg[2];
                    next_flags[`FRCU_B_CARRY] = flags_image_byte_reg[0];
                end else begin
                    next_fault_set = 1'b1;
                end
            end
            `FRCU_OP_PUSHW: begin
                // same in every mode
                next_stack_out = {48'h000000000000,
                                  wide_flags_register[15:0]};
            end
            `FRCU_OP_PUSHD: begin
                next_stack_out = push_img;
            end
            `FRCU_OP_POPW: begin
                // upper half untouched by the word form
                next_flags[31:0] = (wide_flags_register[31:0] & ~pop_mask) |
                                   (pop_src & pop_mask);
            end
            `FRCU_OP_POPD: begin
                next_flags[31:0] = (wide_flags_register[31:0] & ~pop_mask) |
                                   (pop_src & pop_mask);
                next_flags[63:32] = 32'h00000000;
            end
            `FRCU_OP_STEP: begin
                if (wide_flags_register[`FRCU_B_DIR]) begin
                    next_src = source_index_reg - step;
                    next_dst = dest_index_reg - step;
                end else begin
                    next_src = source_index_reg + step;
                    next_dst = dest_index_reg + step;
                end
            end
            default: begin
                next_fault_set = 1'b0;
            end
        endcase
    end

    // state registers; an operation wins over a plain write in its cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wide_flags_register <= `FRCU_RST_FLAGS;
            flags_image_byte_reg <= 8'h00;
            stack_in <= 64'h0000000000000000;
            stack_out <= 64'h0000000000000000;
            mode_reg <= `FRCU_RST_MODE;
            source_index_reg <= 32'h00000000;
            dest_index_reg <= 32'h00000000;
            last_op <= 4'h0;
        end else if (op_go) begin
            wide_flags_register <= next_flags;
            flags_image_byte_reg <= next_byte;
            stack_out <= next_stack_out;
            source_index_reg <= next_src;
            dest_index_reg <= next_dst;
            last_op <= op_code;
        end else if (wr_en) begin
            case (wr_off)
                `FRCU_OFF_FLO: begin
                    wide_flags_register[31:0] <= hwdata;
                end
                `FRCU_OFF_FHI: begin
                    wide_flags_register[63:32] <= hwdata;
                end
                `FRCU_OFF_BYTE: begin
                    flags_image_byte_reg <= hwdata[7:0];
                end
                `FRCU_OFF_SILO: begin
                    stack_in[31:0] <= hwdata;
                end
                `FRCU_OFF_SIHI: begin
                    stack_in[63:32] <= hwdata;
                end
                `FRCU_OFF_MODE: begin
                    mode_reg <= hwdata[4:0];
                end
                `FRCU_OFF_SRC: begin
                    source_index_reg <= hwdata;
                end
                `FRCU_OFF_DST: begin
                    dest_index_reg <= hwdata;
                end
                default: begin
                    last_op <= last_op;
                end
            endcase
        end
    end

    // sticky refusal flag; a new refusal beats a clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_fault <= 1'b0;
        end else if (op_go & next_fault_set) begin
            op_fault <= 1'b1;
        end else if (fault_clr) begin
            op_fault <= 1'b0;
        end
    end

    // interrupt gate: registered so the output is a clean level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_service_req <= 1'b0;
        end else begin
            int_service_req <= maskable_interrupt_pin &
                               wide_flags_register[`FRCU_B_IF];
        end
    end

    // read data registered in the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            case (rd_off)
                `FRCU_OFF_FLO: begin
                    hrdata <= wide_flags_register[31:0];
                end
                `FRCU_OFF_FHI: begin
                    hrdata <= wide_flags_register[63:32];
                end
                `FRCU_OFF_BYTE: begin
                    hrdata <= {24'h000000, flags_image_byte_reg};
                end
                `FRCU_OFF_SILO: begin
                    hrdata <= stack_in[31:0];
                end
                `FRCU_OFF_SIHI: begin
                    hrdata <= stack_in[63:32];
                end
                `FRCU_OFF_SOLO: begin
                    hrdata <= stack_out[31:0];
                end
                `FRCU_OFF_SOHI: begin
                    hrdata <= stack_out[63:32];
                end
                `FRCU_OFF_MODE: begin
                    hrdata <= {27'h0000000, mode_reg};
                end
                `FRCU_OFF_SRC: begin
                    hrdata <= source_index_reg;
                end
                `FRCU_OFF_DST: begin
                    hrdata <= dest_index_reg;
                end
                `FRCU_OFF_STAT: begin
                    hrdata <= {24'h000000, last_op, 2'h0,
                               int_service_req, op_fault};
                end
                default: begin
                    // op register and unmapped space read as zero
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end
endmodule

//--- frcu_regs.vh
`ifndef FRCU_REGS_VH
`define FRCU_REGS_VH
// register byte offsets
`define FRCU_OFF_OP     6'h00
`define FRCU_OFF_FLO    6'h04
`define FRCU_OFF_FHI    6'h08
`define FRCU_OFF_BYTE   6'h0C
`define FRCU_OFF_SILO   6'h10
`define FRCU_OFF_SIHI   6'h14
`define FRCU_OFF_SOLO   6'h18
`define FRCU_OFF_SOHI   6'h1C
`define FRCU_OFF_MODE   6'h20
`define FRCU_OFF_SRC    6'h24
`define FRCU_OFF_DST    6'h28
`define FRCU_OFF_STAT   6'h2C
`define FRCU_OFF_NONE   6'h3F
// operation codes
`define FRCU_OP_CSET    4'h1
`define FRCU_OP_CCLR    4'h2
`define FRCU_OP_CINV    4'h3
`define FRCU_OP_DSET    4'h4
`define FRCU_OP_DCLR    4'h5
`define FRCU_OP_ISET    4'h6
`define FRCU_OP_ICLR    4'h7
`define FRCU_OP_LOADB   4'h8
`define FRCU_OP_STOREB  4'h9
`define FRCU_OP_PUSHW   4'hA
`define FRCU_OP_PUSHD   4'hB
`define FRCU_OP_POPW    4'hC
`define FRCU_OP_POPD    4'hD
`define FRCU_OP_STEP    4'hE
// flag bit positions
`define FRCU_B_CARRY    0
`define FRCU_B_PARITY   2
`define FRCU_B_AUX      4
`define FRCU_B_ZERO     6
`define FRCU_B_SIGN     7
`define FRCU_B_IF       9
`define FRCU_B_DIR      10
`define FRCU_B_IOLVL_LO 12
`define FRCU_B_IOLVL_HI 13
// pop and push masks
`define FRCU_M_POPW     32'h00000DD5
`define FRCU_M_POPD     32'h00240000
`define FRCU_M_IOLVL    32'h00003000
`define FRCU_M_IF       32'h00000200
`define FRCU_M_PUSH_CLR 64'h0000000000030000
// mode register fields
`define FRCU_MD_LONG    0
`define FRCU_MD_PROT    1
`define FRCU_MD_PRIV_LO 2
`define FRCU_MD_PRIV_HI 3
`define FRCU_MD_FEAT    4
// status register fields
`define FRCU_ST_FAULT   0
`define FRCU_ST_INT     1
`define FRCU_ST_OP_LO   4
`define FRCU_ST_OP_HI   7
// reset values
`define FRCU_RST_FLAGS  64'h0000000000000002
`define FRCU_RST_MODE   5'h00
`endif

//--- frcu_ahb.v
`timescale 1ns/1ps
`include "frcu_regs.vh"
module frcu_ahb (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // address phase
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    // decoded access
    output wire        rd_take,
    output wire [5:0]  rd_off,
    output reg         wr_en,
    output reg  [5:0]  wr_off,
    // response
    output reg         hreadyout,
    output reg         hresp
);
    wire       take;
    wire       mapped;
    wire [5:0] off;

    assign take = hsel & htrans[1] & hready;
    // only aligned words up to and including the status register decode
    assign mapped = (haddr[31:6] == 26'h0000000) &
                    (haddr[1:0] == 2'h0) &
                    (haddr[5:0] <= `FRCU_OFF_STAT);
    assign off = mapped ? haddr[5:0] : `FRCU_OFF_NONE;
    assign rd_take = take & ~hwrite;
    assign rd_off = off;

    // zero wait states: write commits at end of data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en <= 1'b0;
            wr_off <= `FRCU_OFF_NONE;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_en <= take & hwrite;
            wr_off <= off;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

//--- frcu_asserts.sv
`timescale 1ns/1ps
`include "frcu_regs.vh"
module frcu_asserts (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // interrupt and flags
    input wire        maskable_interrupt_pin,
    input wire        int_service_req,
    input wire [63:0] wide_flags_register
);
    reg        op_dp;
    wire       op_go;
    wire [3:0] opc;
    assign opc = hwdata[3:0];
    assign op_go = op_dp && hready;
    // data phase of a write to the op register; the op commits at its end
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            op_dp <= 1'b0;
        else if (hready)
            op_dp <= hsel && htrans[1] && hwrite && haddr == 32'h0;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_carry_set: assert property (op_go && opc == `FRCU_OP_CSET |=> wide_flags_register[0])
        else $error("carry not set");
    a_carry_clear: assert property (op_go && opc == `FRCU_OP_CCLR |=> !wide_flags_register[0])
        else $error("carry not cleared");
    a_carry_invert: assert property (op_go && opc == `FRCU_OP_CINV
        |=> wide_flags_register[0] != $past(wide_flags_register[0])) else $error("carry not inverted");
    a_dir_write: assert property (op_go && (opc == `FRCU_OP_DSET || opc == `FRCU_OP_DCLR)
        |=> wide_flags_register[10] == ($past(opc) == `FRCU_OP_DSET)) else $error("direction wrong");
    a_load_keeps: assert property (op_go && opc == `FRCU_OP_LOADB |=> $stable(wide_flags_register))
        else $error("flags changed by byte load");
    a_popw_keeps: assert property (op_go && opc == `FRCU_OP_POPW
        |=> ((wide_flags_register ^ $past(wide_flags_register)) & 64'hFFFFFFFFFFFFC02A) == 64'h0)
        else $error("word pop touched other bits");
    a_popd_upper: assert property (op_go && opc == `FRCU_OP_POPD |=> wide_flags_register[63:32] == 32'h0)
        else $error("upper flags not zero");
    a_int_follow: assert property (int_service_req == ($past(maskable_interrupt_pin) && $past(wide_flags_register[9])))
        else $error("interrupt request not gated");
endmodule
bind frcu_top frcu_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .maskable_interrupt_pin(maskable_interrupt_pin), .int_service_req(int_service_req),
    .wide_flags_register(wide_flags_register));

//--- frcu_master.sv
`timescale 1ns/1ps
module frcu_master (
    // clock and bus return
    input  wire        hclk,
    input  wire        hready,
    input  wire [31:0] hrdata,
    // bus request
    output reg         hsel,
    output reg  [31:0] haddr,
    output reg  [1:0]  htrans,
    output reg         hwrite,
    output reg  [2:0]  hsize,
    output reg  [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // each phase held until hready is seen high; the bound only stops a hang
    task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] rd, output hung);
        integer n;
        begin
            n = 0;
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (!hready && n < 32) begin
                @(posedge hclk);
                n = n + 1;
            end
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (!hready && n < 32) begin
                @(posedge hclk);
                n = n + 1;
            end
            rd = hrdata;
            hung = n >= 32;
        end
    endtask
endmodule

//--- frcu_tb.sv
`timescale 1ns/1ps
`include "frcu_regs.vh"
module frcu_tb;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         maskable_interrupt_pin = 1'b0;
    wire        hsel, hwrite, hready, hresp, int_service_req;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0]  htrans;
    wire [2:0]  hsize;
    wire [63:0] wide_flags_register;
    integer     miscompares = 0;
    integer     n_tests = 0;
    integer     seed = 91;
    integer     i, k;
    reg  [63:0] ef, so, sv;
    reg  [31:0] r, si, di;
    reg  [7:0]  eb;
    reg  [4:0]  md;
    reg  [3:0]  c;
    reg  [1:0]  sz;
    reg         flt;

    always #25 hclk = ~hclk;

    frcu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .maskable_interrupt_pin(maskable_interrupt_pin), .int_service_req(int_service_req),
        .wide_flags_register(wide_flags_register));
    frcu_master m (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task chk(input string nm, input [63:0] seen, input [63:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task bus(input w, input [5:0] a, input [31:0] d);
        reg hung;
        begin
            m.xfer(w, {26'h0, a}, d, r, hung);
            chk("hresp", hresp, 64'h0);
            if (hung) begin
                miscompares = miscompares + 1;
                final_report;
            end
        end
    endtask

    // updates the expected state for op c and returns the expected fault
    function predict(input [3:0] c);
        reg [31:0] mk;
        reg        ok, gate;
        begin
            mk = `FRCU_M_POPW;
            if (md[3:2] == 2'h0)
                mk = mk | `FRCU_M_IOLVL;
            if (ef[13:12] >= md[3:2])
                mk = mk | `FRCU_M_IF;
            ok = !(md[0] && !md[4]);
            gate = !md[1] || ef[13:12] >= md[3:2];
            predict = 1'b0;
            case (c)
                `FRCU_OP_CSET: ef[0] = 1'b1;
                `FRCU_OP_CCLR: ef[0] = 1'b0;
                `FRCU_OP_CINV: ef[0] = ~ef[0];
                `FRCU_OP_DSET: ef[10] = 1'b1;
                `FRCU_OP_DCLR: ef[10] = 1'b0;
                `FRCU_OP_ISET, `FRCU_OP_ICLR: if (gate) ef[9] = c == `FRCU_OP_ISET; else predict = 1'b1;
                `FRCU_OP_LOADB: if (ok) {eb[7:6], eb[4], eb[2], eb[0]} = {ef[7:6], ef[4], ef[2], ef[0]};
                    else predict = 1'b1;
                `FRCU_OP_STOREB: if (ok) {ef[7:6], ef[4], ef[2], ef[0]} = {eb[7:6], eb[4], eb[2], eb[0]};
                    else predict = 1'b1;
                `FRCU_OP_PUSHW: so = {48'h0, ef[15:0]};
                `FRCU_OP_PUSHD: so = ef & ~`FRCU_M_PUSH_CLR & {{32{md[0]}}, 32'hFFFFFFFF};
                `FRCU_OP_POPW: ef[31:0] = (ef[31:0] & ~mk) | (sv[31:0] & mk);
                `FRCU_OP_POPD: begin
                    mk = mk | `FRCU_M_POPD;
                    ef = {32'h0, (ef[31:0] & ~mk) | (sv[31:0] & mk)};
                end
                `FRCU_OP_STEP: begin
                    si = ef[10] ? si - (32'h1 << sz) : si + (32'h1 << sz);
                    di = ef[10] ? di - (32'h1 << sz) : di + (32'h1 << sz);
                end
                default: ;
            endcase
        end
    endfunction

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk("flags_reset", wide_flags_register, `FRCU_RST_FLAGS);
        @(posedge hclk);
        bus(0, 6'h30, 32'h0);
        chk("unmapped", r, 32'h0);
        for (k = 0; k < 12; k = k + 1)
            for (i = 0; i < 16; i = i + 1) begin
                c = i;
                md = $random(seed);
                ef = {$random(seed), $random(seed)} | 64'h2;
                sv = {$random(seed), $random(seed)};
                eb = $random(seed);
                si = $random(seed);
                di = $random(seed);
                sz = $random(seed);
                maskable_interrupt_pin <= $random(seed);
                bus(1, `FRCU_OFF_FLO, ef[31:0]);
                bus(1, `FRCU_OFF_FHI, ef[63:32]);
                bus(1, `FRCU_OFF_MODE, {27'h0, md});
                bus(1, `FRCU_OFF_BYTE, {24'h0, eb});
                bus(1, `FRCU_OFF_SILO, sv[31:0]);
                bus(1, `FRCU_OFF_SIHI, sv[63:32]);
                bus(1, `FRCU_OFF_SRC, si);
                bus(1, `FRCU_OFF_DST, di);
                bus(1, `FRCU_OFF_STAT, 32'h1);
                bus(1, `FRCU_OFF_OP, {26'h0, sz, c});
                flt = predict(c);
                bus(0, `FRCU_OFF_STAT, 32'h0);
                chk("fault", r[0], flt);
                bus(0, `FRCU_OFF_FLO, 32'h0);
                chk("flags_low", r, ef[31:0]);
                chk("flags_port", wide_flags_register, ef);
                bus(0, `FRCU_OFF_BYTE, 32'h0);
                chk("byte", r, eb);
                bus(0, `FRCU_OFF_SRC, 32'h0);
                chk("src_index", r, si);
                bus(0, `FRCU_OFF_DST, 32'h0);
                chk("dst_index", r, di);
                chk("int_req", int_service_req, maskable_interrupt_pin & ef[9]);
                if (c == `FRCU_OP_PUSHW || c == `FRCU_OP_PUSHD) begin
                    bus(0, `FRCU_OFF_SOLO, 32'h0);
                    chk("push_low", r, so[31:0]);
                    bus(0, `FRCU_OFF_SOHI, 32'h0);
                    chk("push_high", r, so[63:32]);
                end
            end
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("flags_rereset", wide_flags_register, `FRCU_RST_FLAGS);
        final_report;
    end
endmodule
